// *** hdl/baud_ref_div.sv ***
`include "uart_fifo_irq_params.svh"
`default_nettype none
module baud_ref_div (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Reference strobe and divisor
  input  wire logic        ref_in_tick,
  input  wire logic [15:0] divisor,
  // Sixteen-times bit rate strobe
  output logic             baud16_tick
);
  logic [3:0]  ref_cnt_r;
  logic        ref_tick;
  logic [15:0] div_cnt_r;

  // Divide the reference strobe by 13
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ref_cnt_r <= 4'h0;
    else if (ref_in_tick)
      ref_cnt_r <= (ref_cnt_r == `REF_DIVIDE - 4'd1) ? 4'h0 : ref_cnt_r + 4'h1;
  end

  assign ref_tick = ref_in_tick && (ref_cnt_r == `REF_DIVIDE - 4'd1);

  // Divide the channel clock by the baud divisor, zero treated as one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt_r   <= 16'h0001;
      baud16_tick <= 1'b0;
    end
    else
    begin
      baud16_tick <= 1'b0;
      if (ref_tick)
      begin
        if (div_cnt_r >= divisor)
        begin
          div_cnt_r   <= 16'h0001;
          baud16_tick <= 1'b1;
        end
        else
          div_cnt_r <= div_cnt_r + 16'h0001;
      end
    end
  end
endmodule // baud_ref_div
`default_nettype wire

// *** hdl/char_timer.sv ***
`default_nettype none
module char_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       tick,
  input  wire logic       restart,
  input  wire logic [9:0] len,
  // Expiry level, held until restart
  output logic            expired
);
  logic [9:0] cnt_r;

  // Count ticks up to the length, then hold
  always_ff @(posedge clk)
  begin
    if (!rst_n || restart)
    begin
      cnt_r   <= 10'h000;
      expired <= 1'b0;
    end
    else if (tick && !expired)
    begin
      cnt_r   <= cnt_r + 10'h001;
      expired <= (cnt_r + 10'h001 >= len);
    end
  end
endmodule // char_timer
`default_nettype wire

// *** hdl/uart_fifo_irq.sv ***
// How it works
// - Control registers writable at any time
// - Channel clock is reference divided by 13
// - FIFO enable plus enable bit 0 arm receive
// - Data-available follows trigger level both ways
// - Line status outranks data available
// - Time-out after four idle character times
// - Receive character clock input measures time-out
// - New character or read restarts time-out
// - Enable bit 1 alone arms transmit, with or without FIFO enable
// - Transmit empty raises; write or id read clears
// - In FIFO mode, delay empty unless two bytes were held
// - Immediate transmit interrupt on FIFO enable change while transmit empty
// - Time-out ranks just below data available
// - Enables cleared gives polled FIFO mode
// - Status bits 7,6,5 report FIFO states
// - Status bits 4-1 sticky character errors
// - Status bit 0 while receive FIFO holds data
// - Polled mode shows no trigger or time-out
// - Reset gives line status 0x60
// - Reset gives id register 0x01
`include "uart_fifo_irq_params.svh"
`default_nettype none
module uart_fifo_irq (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Reference strobe and receiver character clock
  input  wire logic        ref_in_tick,
  input  wire logic        receiver_char_clock,
  // Receive path
  input  wire logic        rx_char_valid,
  input  wire logic [3:0]  rx_char_err,
  input  wire logic [4:0]  rx_fifo_count,
  input  wire logic [7:0]  rx_fifo_data,
  input  wire logic        rx_fifo_error,
  output logic             rx_pop,
  // Transmit path
  input  wire logic [4:0]  tx_fifo_count,
  input  wire logic        tx_shift_empty,
  output logic             tx_push,
  output logic [7:0]       tx_data,
  // Channel control
  output logic             fifo_enable,
  output logic             fifo_rx_reset,
  output logic             fifo_tx_reset,
  output logic [7:0]       line_control,
  output logic [4:0]       modem_control,
  output logic             baud16_tick,
  output logic             irq
);
  import uart_fifo_irq_pkg::*;

  logic [3:0]  ier_r;
  logic        fen_r;
  logic [1:0]  trig_r;
  logic [7:0]  lcr_r;
  logic [4:0]  mcr_r;
  logic [7:0]  dll_r;
  logic [7:0]  dlm_r;
  logic [3:0]  lsr_err_r;
  logic        receiver_char_clock_prev_r;
  logic        transmit_holding_empty_irq_r;
  logic        two_seen_r;
  logic        id_transmit_holding_empty_read_r;
  tx_state_t   tx_st_r;
  tx_state_t   tx_st_nxt;
  iid_t        iid;
  logic        setup_rd;
  logic        acc_rd;
  logic        acc_wr;
  logic        mapped;
  logic        receiver_char_clock_tick;
  logic        rx_arm;
  logic        rda_pend;
  logic        tmo_exp;
  logic        tmo_pend;
  logic        rls_pend;
  logic        tx_dly_done;
  logic        tx_empty_ind;
  logic        tx_becomes_empty;
  logic        fen_changed;
  logic [4:0]  trig_lvl;
  logic [7:0]  line_status;
  logic [7:0]  interrupt_identification_register;
  logic [9:0]  char16;

  // Character time in 16x ticks: start, data, parity, stop bits
  function automatic logic [9:0] char_ticks(input logic [7:0] lc);
    logic [9:0] bits;
    bits = `CHAR_BASE_BITS + {8'h00, lc[1:0]} + {9'h000, lc[`LC_PARITY]}
         + {9'h000, lc[`LC_STOP]};
    char_ticks = bits * `TICKS_PER_BIT;
  endfunction

  // APB decode; single-cycle access phase
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_rd   = psel && penable && !pwrite;
  assign acc_wr   = psel && penable && pwrite;
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= `OFS_DIV_HIGH);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  // Control register writes, accepted at any time
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ier_r  <= `RST_INT_ENABLE;
      fen_r  <= 1'b0;
      trig_r <= `RST_TRIG_SEL;
      lcr_r  <= `RST_LINE_CTRL;
      mcr_r  <= `RST_MODEM_CTRL;
      dll_r  <= `RST_DIV_LOW;
      dlm_r  <= `RST_DIV_HIGH;
    end
    else if (acc_wr)
    begin
      unique case (paddr)
        `OFS_INT_ENABLE:  ier_r <= pwdata[3:0];
        `OFS_INT_ID_FCTL:
        begin
          fen_r  <= pwdata[`FC_ENABLE];
          trig_r <= pwdata[`FC_TRIG_LSB +: 2];
        end
        `OFS_LINE_CTRL:   lcr_r <= pwdata[7:0];
        `OFS_MODEM_CTRL:  mcr_r <= pwdata[4:0];
        `OFS_DIV_LOW:     dll_r <= pwdata[7:0];
        `OFS_DIV_HIGH:    dlm_r <= pwdata[7:0];
        default:          ;
      endcase
    end
  end

  // Transmit push and FIFO reset pulses
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_push       <= 1'b0;
      tx_data       <= 8'h00;
      fifo_rx_reset <= 1'b0;
      fifo_tx_reset <= 1'b0;
    end
    else
    begin
      tx_push       <= acc_wr && (paddr == `OFS_DATA);
      fifo_rx_reset <= acc_wr && (paddr == `OFS_INT_ID_FCTL) && pwdata[`FC_RX_RESET];
      fifo_tx_reset <= acc_wr && (paddr == `OFS_INT_ID_FCTL) && pwdata[`FC_TX_RESET];
      if (acc_wr && (paddr == `OFS_DATA))
        tx_data <= pwdata[7:0];
    end
  end

  assign rx_pop        = acc_rd && (paddr == `OFS_DATA);
  assign fifo_enable   = fen_r;
  assign line_control  = lcr_r;
  assign modem_control = mcr_r;
  assign fen_changed   = acc_wr && (paddr == `OFS_INT_ID_FCTL) && (pwdata[`FC_ENABLE] != fen_r);

  // Channel clock: reference divided by 13, then by the divisor
  baud_ref_div u_baud (
    .clk         (clk),
    .rst_n       (rst_n),
    .ref_in_tick (ref_in_tick),
    .divisor     ({dlm_r, dll_r}),
    .baud16_tick (baud16_tick)
  );

  assign char16 = char_ticks(lcr_r);

  // Receiver character clock rising edges
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      receiver_char_clock_prev_r <= 1'b0;
    else
      receiver_char_clock_prev_r <= receiver_char_clock;
  end

  assign receiver_char_clock_tick = receiver_char_clock && !receiver_char_clock_prev_r;

  // Receive trigger level
  always_comb
  begin
    unique case (trig_r)
      2'd0: trig_lvl = `TRIG_LVL0;
      2'd1: trig_lvl = `TRIG_LVL1;
      2'd2: trig_lvl = `TRIG_LVL2;
      2'd3: trig_lvl = `TRIG_LVL3;
    endcase
  end

  // Receive sources, armed only by FIFO enable and enable bit 0
  assign rx_arm   = fen_r && ier_r[`IE_RX_DATA];
  assign rda_pend = rx_arm && (rx_fifo_count >= trig_lvl);
  assign tmo_pend = rx_arm && (rx_fifo_count != 5'd0) && tmo_exp;

  // Time-out: four character times, restarted by receive or read
  char_timer u_rx_tmo (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (receiver_char_clock_tick),
    .restart (rx_char_valid || rx_pop || !rx_arm || rx_fifo_count == 5'd0),
    .len     (char16 * {7'h00, `TIMEOUT_CHARS}),
    .expired (tmo_exp)
  );

  // Sticky character errors; a new error wins over the read clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lsr_err_r <= 4'h0;
    else
      lsr_err_r <= (lsr_err_r & ~{4{acc_rd && paddr == `OFS_LINE_STATUS}})
                 | ({4{rx_char_valid}} & rx_char_err);
  end

  assign rls_pend = ier_r[`IE_LINE_STAT] && (lsr_err_r != 4'h0);

  // Transmit empty indication with optional delay of one character minus a stop bit
  always_comb
  begin
    tx_st_nxt = tx_st_r;
    unique case (tx_st_r)
      TX_EMPTY: if (tx_fifo_count != 5'd0) tx_st_nxt = TX_BUSY;
      TX_BUSY:
        if (tx_fifo_count == 5'd0)
          tx_st_nxt = (fen_r && !two_seen_r) ? TX_DELAY : TX_EMPTY;
      TX_DELAY:
        if (tx_fifo_count != 5'd0)
          tx_st_nxt = TX_BUSY;
        else if (tx_dly_done)
          tx_st_nxt = TX_EMPTY;
      default: tx_st_nxt = TX_EMPTY;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_st_r <= TX_EMPTY;
    else
      tx_st_r <= tx_st_nxt;
  end

  // Two bytes held at once since the indication was last set
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      two_seen_r <= 1'b0;
    else if (tx_fifo_count >= 5'd2)
      two_seen_r <= 1'b1;
    else if (tx_st_nxt == TX_EMPTY && tx_st_r != TX_EMPTY)
      two_seen_r <= 1'b0;
  end

  // Delay of one character minus the last stop bit
  char_timer u_tx_dly (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (baud16_tick),
    .restart (tx_st_r != TX_DELAY),
    .len     (char16 - `TICKS_PER_BIT),
    .expired (tx_dly_done)
  );

  assign tx_empty_ind     = (tx_st_r == TX_EMPTY);
  assign tx_becomes_empty = (tx_st_nxt == TX_EMPTY) && (tx_st_r != TX_EMPTY);

  // Transmit interrupt: set on empty, or on FIFO enable change while empty; set wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      transmit_holding_empty_irq_r <= 1'b0;
    else if (ier_r[`IE_TX_EMPTY] && (tx_becomes_empty || (fen_changed && tx_empty_ind)))
      transmit_holding_empty_irq_r <= 1'b1;
    else if (acc_wr && paddr == `OFS_INT_ENABLE && pwdata[`IE_TX_EMPTY]
             && !ier_r[`IE_TX_EMPTY] && tx_empty_ind)
      transmit_holding_empty_irq_r <= 1'b1;
    else if (tx_push || (acc_rd && paddr == `OFS_INT_ID_FCTL && id_transmit_holding_empty_read_r))
      transmit_holding_empty_irq_r <= 1'b0;
  end

  // Priority encoder: line status, then receive, then transmit
  always_comb
  begin
    if (rls_pend)
      iid = IID_RLS;
    else if (rda_pend)
      iid = IID_RDA;
    else if (tmo_pend)
      iid = IID_TMO;
    else if (transmit_holding_empty_irq_r && ier_r[`IE_TX_EMPTY])
      iid = IID_TRANSMIT_HOLDING_EMPTY;
    else
      iid = IID_NONE;
  end

  assign irq = (iid != IID_NONE);
  assign interrupt_identification_register = {fen_r, fen_r, 2'b00, iid};
  assign line_status = {fen_r && rx_fifo_error, tx_empty_ind && tx_shift_empty, tx_empty_ind,
                lsr_err_r, rx_fifo_count != 5'd0};

  // Read data captured in the setup phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata         <= 32'h0000_0000;
      id_transmit_holding_empty_read_r <= 1'b0;
    end
    else if (setup_rd)
    begin
      id_transmit_holding_empty_read_r <= (paddr == `OFS_INT_ID_FCTL) && (iid == IID_TRANSMIT_HOLDING_EMPTY);
      unique case (paddr)
        `OFS_DATA:        prdata <= {24'h000000, rx_fifo_data};
        `OFS_INT_ENABLE:  prdata <= {28'h0000000, ier_r};
        `OFS_INT_ID_FCTL: prdata <= {24'h000000, interrupt_identification_register};
        `OFS_LINE_CTRL:   prdata <= {24'h000000, lcr_r};
        `OFS_MODEM_CTRL:  prdata <= {27'h0000000, mcr_r};
        `OFS_LINE_STATUS: prdata <= {24'h000000, line_status};
        `OFS_DIV_LOW:     prdata <= {24'h000000, dll_r};
        `OFS_DIV_HIGH:    prdata <= {24'h000000, dlm_r};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rda_trigger: assert property (
    (rx_arm && rx_fifo_count >= trig_lvl && !rls_pend) |-> iid == IID_RDA)
    else $error("data available not flagged at trigger level");
  a_rda_polled: assert property (
    !ier_r[`IE_RX_DATA] |-> (iid != IID_RDA && iid != IID_TMO))
    else $error("receive source raised in polled mode");
  a_rls_priority: assert property (
    rls_pend |-> iid == IID_RLS)
    else $error("line status not top priority");
  a_tmo_restart: assert property (
    rx_pop |=> !tmo_exp)
    else $error("time-out survived a host read");
  a_tmo_needs_data: assert property (
    (iid == IID_TMO) |-> (rx_fifo_count != 5'd0 && fen_r))
    else $error("time-out with empty FIFO");
  a_transmit_holding_empty_clear: assert property (
    (tx_push && !tx_becomes_empty && !fen_changed) |=> !transmit_holding_empty_irq_r)
    else $error("transmit interrupt not cleared by write");
  a_tx_delay: assert property (
    (tx_st_r == TX_BUSY && tx_fifo_count == 5'd0 && fen_r && !two_seen_r)
      |=> !tx_empty_ind)
    else $error("empty indication not delayed");
  a_fen_immediate: assert property (
    (fen_changed && ier_r[`IE_TX_EMPTY] && tx_empty_ind) |=> transmit_holding_empty_irq_r)
    else $error("no immediate interrupt on enable change");
  a_lsr_data: assert property (
    line_status[0] == (rx_fifo_count != 5'd0))
    else $error("status bit 0 wrong");
  a_reset_vals: assert property (
    $rose(rst_n) |-> (interrupt_identification_register == 8'h01 && line_status[4:1] == 4'h0 && !irq))
    else $error("wrong values after reset");
  a_irq_line: assert property (
    irq == (interrupt_identification_register[0] == 1'b0))
    else $error("interrupt output disagrees with id");

  c_timeout:  cover property (iid == IID_TMO);
  c_tx_delay: cover property (tx_st_r == TX_DELAY ##1 tx_st_r == TX_EMPTY);
  c_rls:      cover property (iid == IID_RLS);
  c_transmit_holding_empty_rd:  cover property (transmit_holding_empty_irq_r ##1 !transmit_holding_empty_irq_r);
endmodule // uart_fifo_irq
`default_nettype wire

// *** hdl/uart_fifo_irq_params.svh ***
`ifndef UART_FIFO_IRQ_PARAMS_SVH
`define UART_FIFO_IRQ_PARAMS_SVH

// Register byte offsets on the APB slave
`define OFS_DATA        8'h00
`define OFS_INT_ENABLE  8'h04
`define OFS_INT_ID_FCTL 8'h08
`define OFS_LINE_CTRL   8'h0c
`define OFS_MODEM_CTRL  8'h10
`define OFS_LINE_STATUS 8'h14
`define OFS_DIV_LOW     8'h18
`define OFS_DIV_HIGH    8'h1c

// Reset values
`define RST_INT_ENABLE  4'h0
`define RST_LINE_CTRL   8'h00
`define RST_MODEM_CTRL  5'h00
`define RST_DIV_LOW     8'h01
`define RST_DIV_HIGH    8'h00
`define RST_TRIG_SEL    2'h0

// Interrupt enable bit positions
`define IE_RX_DATA      0
`define IE_TX_EMPTY     1
`define IE_LINE_STAT    2

// FIFO control bit positions
`define FC_ENABLE       0
`define FC_RX_RESET     1
`define FC_TX_RESET     2
`define FC_TRIG_LSB     6

// Line control bit positions
`define LC_STOP         2
`define LC_PARITY       3

// Receive trigger levels in bytes
`define TRIG_LVL0       5'd1
`define TRIG_LVL1       5'd4
`define TRIG_LVL2       5'd8
`define TRIG_LVL3       5'd14

// Timing: reference input of 24 MHz divided by 13, 16 ticks per bit
`define REF_DIVIDE      4'd13
`define TICKS_PER_BIT   10'd16
`define TIMEOUT_CHARS   3'd4
`define CHAR_BASE_BITS  10'd7

`endif

// *** hdl/uart_fifo_irq_pkg.sv ***
`default_nettype none
package uart_fifo_irq_pkg;
  // Interrupt identification codes, low nibble of the id register
  typedef enum logic [3:0] {
    IID_NONE = 4'h1,
    IID_TRANSMIT_HOLDING_EMPTY = 4'h2,
    IID_RDA  = 4'h4,
    IID_RLS  = 4'h6,
    IID_TMO  = 4'hc
  } iid_t;

  // Transmit-empty indication states
  typedef enum logic [2:0] {
    TX_EMPTY = 3'b001,
    TX_BUSY  = 3'b010,
    TX_DELAY = 3'b100
  } tx_state_t;
endpackage
`default_nettype wire

// *** test/serial_far_end.sv ***
`default_nettype none
module serial_far_end (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Receive side
  input  wire logic rx_pop,
  input  wire logic fifo_rx_reset,
  output logic      rx_char_valid,
  output logic [3:0] rx_char_err,
  output logic [4:0] rx_fifo_count,
  output logic [7:0] rx_fifo_data,
  output logic      rx_fifo_error,
  output logic      receiver_char_clock,
  output logic      ref_in_tick,
  // Transmit side
  input  wire logic tx_push,
  input  wire logic fifo_tx_reset,
  output logic [4:0] tx_fifo_count,
  output logic      tx_shift_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] inq[$];
  logic [11:0] rxq[$];
  logic [1:0]  phase = 2'h0;
  int          tx_n = 0;
  int          shift_left = 0;
  int          errs;

  // Queues a character on the line; one arrives per clock
  task automatic send(input logic [7:0] d, input logic [3:0] e);
    inq.push_back({e, d});
  endtask

  // Quiet line at time zero
  initial
  begin
    rx_char_valid = 1'b0;
    rx_char_err = 4'h0;
    rx_fifo_count = 5'h0;
    rx_fifo_data = 8'h00;
    rx_fifo_error = 1'b0;
    receiver_char_clock = 1'b0;
    ref_in_tick = 1'b0;
    tx_fifo_count = 5'h0;
    tx_shift_empty = 1'b1;
  end

  // Receive FIFO, reference strobe and 16x receive clock
  always @(posedge clk)
  begin
    rx_char_valid <= 1'b0;
    ref_in_tick <= ~ref_in_tick;
    phase <= phase + 2'h1;
    receiver_char_clock <= phase[1];
    if (!rst_n || fifo_rx_reset)
      rxq.delete();
    else
    begin
      if (rx_pop && rxq.size() > 0)
        void'(rxq.pop_front());
      if (inq.size() > 0 && rxq.size() < 16)
      begin
        rxq.push_back(inq[0]);
        rx_char_err <= inq[0][11:8];
        rx_char_valid <= 1'b1;
        void'(inq.pop_front());
      end
    end
    errs = 0;
    foreach (rxq[i])
      if (rxq[i][11:8] != 4'h0)
        errs++;
    rx_fifo_error <= errs > 0;
    rx_fifo_count <= 5'(rxq.size());
    // Empty head shows a changing pattern, never stale data
    rx_fifo_data <= rxq.size() > 0 ? rxq[0][7:0] : ~rx_fifo_data;
  end

  // Transmit FIFO drained by a slow shifter
  always @(posedge clk)
  begin
    // Shifter loads before the push, so a pushed byte shows for a cycle
    if (!rst_n)
      shift_left = 0;
    else if (shift_left > 0)
      shift_left--;
    else if (tx_n > 0)
    begin
      tx_n--;
      shift_left = 300;
    end
    if (!rst_n || fifo_tx_reset)
      tx_n = 0;
    else if (tx_push && tx_n < 16)
      tx_n++;
    tx_fifo_count <= 5'(tx_n);
    tx_shift_empty <= shift_left == 0;
  end
endmodule // serial_far_end
`default_nettype wire

// *** test/test_uart_fifo_irq.sv ***
`include "uart_fifo_irq_params.svh"
`default_nettype none
module test_uart_fifo_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        ref_in_tick, receiver_char_clock, rx_char_valid, rx_fifo_error;
  logic [3:0]  rx_char_err;
  logic [4:0]  rx_fifo_count, tx_fifo_count;
  logic [7:0]  rx_fifo_data, tx_data;
  logic        rx_pop, tx_shift_empty, tx_push, fifo_rx_reset, fifo_tx_reset, irq, fifo_enable;
  logic [32:0] expq[$];
  logic [7:0]  txq[$];
  logic [7:0]  d[6];
  int          num_errors, check_count, n;

  uart_fifo_irq uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_in_tick(ref_in_tick), .receiver_char_clock(receiver_char_clock),
    .rx_char_valid(rx_char_valid), .rx_char_err(rx_char_err), .rx_fifo_count(rx_fifo_count),
    .rx_fifo_data(rx_fifo_data), .rx_fifo_error(rx_fifo_error), .rx_pop(rx_pop),
    .tx_fifo_count(tx_fifo_count), .tx_shift_empty(tx_shift_empty), .tx_push(tx_push),
    .tx_data(tx_data), .fifo_enable(fifo_enable), .fifo_rx_reset(fifo_rx_reset),
    .fifo_tx_reset(fifo_tx_reset),
    .line_control(), .modem_control(), .baud16_tick(), .irq(irq));

  serial_far_end far_end (.clk(clk), .rst_n(rst_n), .rx_pop(rx_pop),
    .fifo_rx_reset(fifo_rx_reset), .rx_char_valid(rx_char_valid), .rx_char_err(rx_char_err),
    .rx_fifo_count(rx_fifo_count), .rx_fifo_data(rx_fifo_data), .rx_fifo_error(rx_fifo_error),
    .receiver_char_clock(receiver_char_clock), .ref_in_tick(ref_in_tick), .tx_push(tx_push),
    .fifo_tx_reset(fifo_tx_reset), .tx_fifo_count(tx_fifo_count),
    .tx_shift_empty(tx_shift_empty));

  // Clock of 25 ns
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Ends the run when a wait used up its bound
  task automatic bound(input int i, input int lim);
    if (i >= lim)
    begin
      num_errors++;
      $display("Error wait expected done seen expired");
      conclude();
    end
  endtask

  // One APB transfer; read expectations go to the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v,
                     input logic [32:0] exp);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    if (!wr)
      expq.push_back(exp);
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    bound(i, 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0, exp);
  endtask

  task automatic wait_cnt(input logic [4:0] c);
    n = 0;
    while (rx_fifo_count !== c && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    bound(n, 40);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 6000)
    begin
      @(posedge clk);
      n++;
    end
    bound(n, 6000);
  endtask

  // Read responses compared against the oldest note
  always @(posedge clk)
    if (psel && penable && !pwrite && pready === 1'b1)
      check("read response", {pslverr, prdata}, expq.pop_front());

  // Pushed bytes compared against the oldest written byte
  always @(posedge clk)
    if (tx_push === 1'b1)
      check("tx data", 33'(tx_data), 33'(txq.pop_front()));

  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    bound(1, 1);
  end

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    check_count = 0;
    void'($urandom(32'hef4b61ab));
    foreach (d[i])
      d[i] = 8'($urandom());
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFS_LINE_STATUS, 33'h60);
    rd(`OFS_INT_ID_FCTL, 33'h01);
    rd(8'h20, {1'b1, 32'h0});
    $display("Test reset done");
    // Soft reset sequence, enables last
    wr(`OFS_LINE_CTRL, 32'h0);
    wr(`OFS_DIV_LOW, 32'h1);
    wr(`OFS_DIV_HIGH, 32'h0);
    wr(`OFS_MODEM_CTRL, 32'h15);
    rd(`OFS_MODEM_CTRL, 33'h15);
    rd(`OFS_LINE_STATUS, 33'h60);
    wr(`OFS_INT_ID_FCTL, 32'h43);
    wr(`OFS_INT_ENABLE, 32'h1);
    // Trigger level of four
    for (int i = 0; i < 3; i++)
      far_end.send(d[i], 4'h0);
    wait_cnt(5'd3);
    rd(`OFS_INT_ID_FCTL, 33'hc1);
    far_end.send(d[3], 4'h0);
    wait_cnt(5'd4);
    rd(`OFS_INT_ID_FCTL, 33'hc4);
    @(negedge clk);
    check("irq", 33'(irq), 33'h1);
    rd(`OFS_DATA, {25'h0, d[0]});
    rd(`OFS_INT_ID_FCTL, 33'hc1);
    rd(`OFS_LINE_STATUS, 33'h61);
    $display("Test trigger level done");
    // Idle line: no time-out under four character times, one after
    repeat (1500) @(posedge clk);
    rd(`OFS_INT_ID_FCTL, 33'hc1);
    repeat (1000) @(posedge clk);
    rd(`OFS_INT_ID_FCTL, 33'hcc);
    rd(`OFS_DATA, {25'h0, d[1]});
    rd(`OFS_INT_ID_FCTL, 33'hc1);
    $display("Test time-out done");
    // Line status outranks data available
    wr(`OFS_INT_ENABLE, 32'h5);
    far_end.send(d[4], 4'h0);
    far_end.send(d[5], 4'h4);
    wait_cnt(5'd4);
    rd(`OFS_INT_ID_FCTL, 33'hc6);
    rd(`OFS_LINE_STATUS, 33'he9);
    rd(`OFS_LINE_STATUS, 33'he1);
    rd(`OFS_INT_ID_FCTL, 33'hc4);
    $display("Test priority done");
    // Polled mode
    wr(`OFS_INT_ENABLE, 32'h0);
    repeat (2500) @(posedge clk);
    rd(`OFS_INT_ID_FCTL, 33'hc1);
    @(negedge clk);
    check("irq", 33'(irq), 33'h0);
    $display("Test polled done");
    // Transmit empty interrupt and its delay
    wr(`OFS_INT_ID_FCTL, 32'h43);
    wr(`OFS_INT_ENABLE, 32'h2);
    rd(`OFS_INT_ID_FCTL, 33'hc2);
    rd(`OFS_INT_ID_FCTL, 33'hc1);
    txq.push_back(d[2]);
    wr(`OFS_DATA, {24'h0, d[2]});
    wait_irq();
    check("tx empty delay", 33'(n > 2000), 33'h1);
    txq.push_back(d[3]);
    wr(`OFS_DATA, {24'h0, d[3]});
    // Push pulse lands one edge after the write, the clear one edge later
    repeat (2) @(negedge clk);
    check("irq", 33'(irq), 33'h0);
    wait_irq();
    rd(`OFS_INT_ID_FCTL, 33'hc2);
    wr(`OFS_INT_ID_FCTL, 32'h0);
    rd(`OFS_INT_ID_FCTL, 33'h02);
    check("fifo enable", 33'(fifo_enable), 33'h0);
    $display("Test transmit done");
    conclude();
  end
endmodule // test_uart_fifo_irq
`default_nettype wire
